// >>> common/dht_pkg.sv
// What this block does
// - halt instruction enters debug after next latch load
// - trace counter counts executed, not aborted, instructions
// - trace at zero enters debug after instruction
// - breakpoint at zero count enters debug
// - fetch breakpoint halts after that instruction
// - data breakpoint halts one instruction later
// - program bus value saved, link reads and writes
// - instruction latch saved, link read only
// - plain bus write restores instruction latch
// - core writes exchange latch, link reads it
// - exchange latch shifted out on read command
// - fetch address captured, frozen in debug
// - decode address captured, frozen in debug
// - execute address captured, frozen in debug
// - twelve entry circular trace, read advances pointer
// - entry points trace reads at oldest entry
// - flow change stores address and taken target
// - invalid bit marks not taken, shifted first
// - 8-bit commands, 24 data bits, lsb first
// - debug entry sets state 11, pulses acknowledge
// - acknowledge pulses on entry and executed instruction
package dht_pkg;
  localparam int DATA_W = 24;
  localparam int ENTRY_W = 25;
  localparam int CMD_W = 8;
  localparam int TRACE_DEPTH = 12;
  localparam int PTR_W = 4;
  // command layout
  localparam int CMD_RD_BIT = 7;
  localparam int CMD_GO_BIT = 6;
  localparam int CMD_EX_BIT = 5;
  localparam int CMD_SEL_LO = 0;
  localparam int SEL_W = 4;
  // register selects
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_PBUS = 4'h1;
  localparam logic [3:0] SEL_INSTR = 4'h2;
  localparam logic [3:0] SEL_EXCH = 4'h3;
  localparam logic [3:0] SEL_FETCH = 4'h4;
  localparam logic [3:0] SEL_DECODE = 4'h5;
  localparam logic [3:0] SEL_EXEC = 4'h6;
  localparam logic [3:0] SEL_TRACE = 4'h7;
  localparam logic [3:0] SEL_TRACE_CNT = 4'h8;
  localparam logic [3:0] SEL_BP_CNT = 4'h9;
  // core side
  localparam logic [23:0] XIO_EXCH_ADDR = 24'hfffffc;
  localparam logic [1:0] CORE_STATE_RUN = 2'h0;
  localparam logic [1:0] CORE_STATE_DEBUG = 2'h3;
  localparam logic [23:0] COUNT_RESET = 24'h000000;
  typedef enum logic [1:0] {ST_CMD, ST_RD, ST_WR, ST_EXEC} dht_state_type;
endpackage

// >>> hw/dht_debug_halt.sv
module dht_debug_halt #(
  parameter int TRACE_DEPTH = dht_pkg::TRACE_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial link pins
  input wire logic tckPin,
  input wire logic tdiPin,
  input wire logic shiftPin,
  input wire logic updatePin,
  output logic tdo_r,
  output logic haltAckN_r,
  output logic [1:0] coreState_r,
  // core execution status
  input wire logic instrExec,
  input wire logic instrAbort,
  input wire logic execIsHalt,
  input wire logic execIsCondHalt,
  input wire logic condTrue,
  input wire logic ilLoad,
  input wire logic traceEnable,
  input wire logic bpEnable,
  input wire logic bpMatchFetch,
  input wire logic bpMatchData,
  // core pipeline values
  input wire logic [23:0] progBusVal,
  input wire logic [23:0] instrLatchVal,
  input wire logic [23:0] fetchAddr,
  input wire logic [23:0] decodeAddr,
  input wire logic [23:0] execAddr,
  // core x io writes
  input wire logic xioWrite,
  input wire logic [23:0] xioAddr,
  input wire logic [23:0] xioData,
  // change of flow reports
  input wire logic cofValid,
  input wire logic cofCond,
  input wire logic cofTaken,
  input wire logic [23:0] cofAddr,
  input wire logic [23:0] cofTarget,
  output logic cofReady_r,
  // core control
  output logic debugMode_r,
  output logic execReq_r,
  output logic [23:0] execWord_r,
  output logic ilRestore_r,
  output logic [23:0] ilRestoreWord_r
);
  initial begin
    if (TRACE_DEPTH < 2 || TRACE_DEPTH > 16) begin
      $error("trace depth must be 2 to 16");
    end
  end

  // ******************************
  // link synchronisers
  // ******************************
  logic [3:0] pinS1_r;
  logic [3:0] pinS2_r;
  logic [3:0] pinS3_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinS1_r <= 4'h0;
      pinS2_r <= 4'h0;
      pinS3_r <= 4'h0;
    end else begin
      pinS1_r <= {updatePin, shiftPin, tdiPin, tckPin};
      pinS2_r <= pinS1_r;
      pinS3_r <= pinS2_r;
    end
  end
  logic tckRise;
  logic updRise;
  logic tdiS;
  logic shiftS;
  assign tckRise = pinS2_r[0] & ~pinS3_r[0];
  assign tdiS = pinS2_r[1];
  assign shiftS = pinS2_r[2];
  assign updRise = pinS2_r[3] & ~pinS3_r[3];

  // ******************************
  // declarations
  // ******************************
  logic [24:0] sh_r;
  dht_pkg::dht_state_type st_r;
  dht_pkg::dht_state_type stNxt;
  logic leave_r;
  logic [3:0] selCmd_r;
  logic [23:0] savedPbus_r;
  logic [23:0] savedInstr_r;
  logic [23:0] exch_r;
  logic [23:0] fetchCap_r;
  logic [23:0] decodeCap_r;
  logic [23:0] execCap_r;
  logic [23:0] traceCnt_r;
  logic [23:0] bpCnt_r;
  logic haltPend_r;
  logic dataBpArm_r;
  logic [24:0] traceMem_r [TRACE_DEPTH];
  logic [3:0] wrPtr_r;
  logic [3:0] rdPtr_r;
  logic [24:0] rdVal;
  logic instrDone;
  logic enterNow;
  logic actExec;
  logic actRestore;
  logic actAck;
  logic actExit;
  logic actRead;
  logic [23:0] dataIn;
  logic [7:0] cmdIn;
  logic cmdGo_r;

  function automatic logic [3:0] nextPtr(input logic [3:0] p);
    nextPtr = (p == 4'(TRACE_DEPTH - 1)) ? 4'h0 : p + 4'h1;
  endfunction

  // ******************************
  // debug entry
  // ******************************
  assign instrDone = instrExec & ~instrAbort;
  assign enterNow = ~debugMode_r & (
    (haltPend_r & ilLoad) |
    (instrDone & traceEnable & (traceCnt_r == dht_pkg::COUNT_RESET)) |
    (instrDone & bpEnable & bpMatchFetch &
      (bpCnt_r == dht_pkg::COUNT_RESET)) |
    (instrDone & dataBpArm_r));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      haltPend_r <= 1'b0;
    end else if (enterNow || debugMode_r) begin
      haltPend_r <= 1'b0;
    end else if (instrDone &&
                 (execIsHalt || (execIsCondHalt && condTrue))) begin
      haltPend_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dataBpArm_r <= 1'b0;
    end else if (enterNow || debugMode_r) begin
      dataBpArm_r <= 1'b0;
    end else if (instrDone && bpEnable && bpMatchData &&
                 bpCnt_r == dht_pkg::COUNT_RESET) begin
      dataBpArm_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      traceCnt_r <= dht_pkg::COUNT_RESET;
    end else if (actRestore == 1'b0 && updRise && st_r == dht_pkg::ST_WR &&
                 selCmd_r == dht_pkg::SEL_TRACE_CNT) begin
      traceCnt_r <= dataIn;
    end else if (!debugMode_r && instrDone && traceEnable &&
                 traceCnt_r != dht_pkg::COUNT_RESET) begin
      traceCnt_r <= traceCnt_r - 24'h000001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bpCnt_r <= dht_pkg::COUNT_RESET;
    end else if (updRise && st_r == dht_pkg::ST_WR &&
                 selCmd_r == dht_pkg::SEL_BP_CNT) begin
      bpCnt_r <= dataIn;
    end else if (!debugMode_r && instrDone && bpEnable &&
                 (bpMatchFetch || bpMatchData) &&
                 bpCnt_r != dht_pkg::COUNT_RESET) begin
      bpCnt_r <= bpCnt_r - 24'h000001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      debugMode_r <= 1'b0;
      coreState_r <= dht_pkg::CORE_STATE_RUN;
      haltAckN_r <= 1'b1;
    end else begin
      if (enterNow) begin
        debugMode_r <= 1'b1;
        coreState_r <= dht_pkg::CORE_STATE_DEBUG;
      end else if (actExit) begin
        debugMode_r <= 1'b0;
        coreState_r <= dht_pkg::CORE_STATE_RUN;
      end
      haltAckN_r <= ~(enterNow | actAck);
    end
  end

  // ******************************
  // pipeline captures
  // ******************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      savedInstr_r <= 24'h000000;
      fetchCap_r <= 24'h000000;
      decodeCap_r <= 24'h000000;
      execCap_r <= 24'h000000;
    end else if (enterNow) begin
      savedInstr_r <= instrLatchVal;
      fetchCap_r <= fetchAddr;
      decodeCap_r <= decodeAddr;
      execCap_r <= execAddr;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      savedPbus_r <= 24'h000000;
    end else if (enterNow) begin
      savedPbus_r <= progBusVal;
    end else if (updRise && st_r == dht_pkg::ST_WR &&
                 selCmd_r == dht_pkg::SEL_PBUS) begin
      savedPbus_r <= dataIn;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      exch_r <= 24'h000000;
    end else if (xioWrite && xioAddr == dht_pkg::XIO_EXCH_ADDR) begin
      exch_r <= xioData;
    end
  end

  // ******************************
  // trace feed buffer
  // ******************************
  logic [24:0] buf_r [2];
  logic bufWp_r;
  logic bufRp_r;
  logic [1:0] bufCnt_r;
  logic pend_r;
  logic [23:0] pendTarget_r;
  logic srcValid;
  logic [24:0] srcWord;
  logic pushOk;
  logic popOk;
  logic takeCof;
  logic [1:0] bufCntNxt;
  logic pendNxt;

  always_comb begin
    takeCof = cofValid & cofReady_r & ~debugMode_r;
    srcValid = pend_r | takeCof;
    // entry layout: address above, invalid bit in bit 0
    srcWord = pend_r ? {pendTarget_r, 1'b0} :
      {cofAddr, cofCond & ~cofTaken};
    pushOk = srcValid & (bufCnt_r != 2'h2);
    popOk = (bufCnt_r != 2'h0) & ~debugMode_r;
    bufCntNxt = bufCnt_r + {1'b0, pushOk} - {1'b0, popOk};
    if (takeCof) begin
      pendNxt = cofTaken;
    end else if (pend_r && pushOk) begin
      pendNxt = 1'b0;
    end else begin
      pendNxt = pend_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bufWp_r <= 1'b0;
      bufRp_r <= 1'b0;
      bufCnt_r <= 2'h0;
      pend_r <= 1'b0;
      pendTarget_r <= 24'h000000;
      cofReady_r <= 1'b0;
    end else begin
      if (pushOk) begin
        buf_r[bufWp_r] <= srcWord;
        bufWp_r <= ~bufWp_r;
      end
      if (popOk) begin
        bufRp_r <= ~bufRp_r;
      end
      bufCnt_r <= bufCntNxt;
      pend_r <= pendNxt;
      if (takeCof) begin
        pendTarget_r <= cofTarget;
      end
      cofReady_r <= (bufCntNxt == 2'h0) & ~pendNxt;
    end
  end

  // ******************************
  // trace memory and pointers
  // ******************************
  always_ff @(posedge clk) begin
    if (popOk) begin
      traceMem_r[wrPtr_r] <= buf_r[bufRp_r];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_r <= 4'h0;
    end else if (popOk) begin
      wrPtr_r <= nextPtr(wrPtr_r);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdPtr_r <= 4'h0;
    end else if (enterNow) begin
      rdPtr_r <= wrPtr_r;
    end else if (actRead && cmdIn[3:0] == dht_pkg::SEL_TRACE) begin
      rdPtr_r <= nextPtr(rdPtr_r);
    end
  end

  // ******************************
  // command decode
  // ******************************
  always_comb begin
    cmdIn = sh_r[24:17];
    dataIn = sh_r[24:1];
    stNxt = st_r;
    actExec = 1'b0;
    actRestore = 1'b0;
    actAck = 1'b0;
    actExit = 1'b0;
    actRead = 1'b0;
    case (st_r)
      dht_pkg::ST_CMD: begin
        if (updRise) begin
          if (cmdIn[dht_pkg::CMD_RD_BIT]) begin
            actRead = 1'b1;
            stNxt = dht_pkg::ST_RD;
          end else if (cmdIn[3:0] != dht_pkg::SEL_NONE) begin
            stNxt = dht_pkg::ST_WR;
          end else if (cmdIn[dht_pkg::CMD_GO_BIT]) begin
            actExec = 1'b1;
            actExit = cmdIn[dht_pkg::CMD_EX_BIT];
            actAck = cmdIn[dht_pkg::CMD_EX_BIT];
            stNxt = cmdIn[dht_pkg::CMD_EX_BIT] ? dht_pkg::ST_CMD :
              dht_pkg::ST_EXEC;
          end else begin
            actAck = 1'b1;
          end
        end
      end
      dht_pkg::ST_RD: begin
        if (updRise) begin
          actAck = 1'b1;
          stNxt = dht_pkg::ST_CMD;
        end
      end
      dht_pkg::ST_WR: begin
        if (updRise) begin
          stNxt = dht_pkg::ST_CMD;
          if (selCmd_r == dht_pkg::SEL_PBUS && cmdGo_r) begin
            actExec = 1'b1;
            actExit = leave_r;
            actAck = leave_r;
            stNxt = leave_r ? dht_pkg::ST_CMD : dht_pkg::ST_EXEC;
          end else if (selCmd_r == dht_pkg::SEL_PBUS && !leave_r) begin
            actRestore = 1'b1;
            actAck = 1'b1;
          end else begin
            actExit = leave_r;
            actAck = 1'b1;
          end
        end
      end
      dht_pkg::ST_EXEC: begin
        if (instrDone) begin
          actAck = 1'b1;
          stNxt = dht_pkg::ST_CMD;
        end
      end
      default: stNxt = dht_pkg::ST_CMD;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= dht_pkg::ST_CMD;
      selCmd_r <= dht_pkg::SEL_NONE;
      leave_r <= 1'b0;
      cmdGo_r <= 1'b0;
    end else begin
      st_r <= stNxt;
      if (st_r == dht_pkg::ST_CMD && updRise) begin
        selCmd_r <= cmdIn[3:0];
        leave_r <= cmdIn[dht_pkg::CMD_EX_BIT];
        cmdGo_r <= cmdIn[dht_pkg::CMD_GO_BIT];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      execReq_r <= 1'b0;
      execWord_r <= 24'h000000;
      ilRestore_r <= 1'b0;
      ilRestoreWord_r <= 24'h000000;
    end else begin
      execReq_r <= actExec;
      ilRestore_r <= actRestore;
      if (actExec) begin
        execWord_r <= (st_r == dht_pkg::ST_WR) ? dataIn : savedPbus_r;
      end
      if (actRestore) begin
        ilRestoreWord_r <= dataIn;
      end
    end
  end

  // ******************************
  // serial shifter
  // ******************************
  always_comb begin
    case (cmdIn[3:0])
      dht_pkg::SEL_PBUS: rdVal = {1'b0, savedPbus_r};
      dht_pkg::SEL_INSTR: rdVal = {1'b0, savedInstr_r};
      dht_pkg::SEL_EXCH: rdVal = {1'b0, exch_r};
      dht_pkg::SEL_FETCH: rdVal = {1'b0, fetchCap_r};
      dht_pkg::SEL_DECODE: rdVal = {1'b0, decodeCap_r};
      dht_pkg::SEL_EXEC: rdVal = {1'b0, execCap_r};
      dht_pkg::SEL_TRACE: rdVal = traceMem_r[rdPtr_r];
      dht_pkg::SEL_TRACE_CNT: rdVal = {1'b0, traceCnt_r};
      dht_pkg::SEL_BP_CNT: rdVal = {1'b0, bpCnt_r};
      default: rdVal = 25'h0000000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_r <= 25'h0000000;
    end else if (actRead) begin
      sh_r <= rdVal;
    end else if (tckRise && shiftS) begin
      sh_r <= {tdiS, sh_r[24:1]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tdo_r <= 1'b0;
    end else begin
      tdo_r <= sh_r[0];
    end
  end

  // ******************************
  // assertions
  // ******************************
  entryAck_a: assert property (@(posedge clk) disable iff (rst)
    enterNow |=> !haltAckN_r)
    else $error("no acknowledge pulse on debug entry");
  entryState_a: assert property (@(posedge clk) disable iff (rst)
    enterNow |=> coreState_r == dht_pkg::CORE_STATE_DEBUG && debugMode_r)
    else $error("core state not set on entry");
  traceDec_a: assert property (@(posedge clk) disable iff (rst)
    !debugMode_r && instrDone && traceEnable && traceCnt_r != 24'h0 &&
    st_r != dht_pkg::ST_WR |=> traceCnt_r == $past(traceCnt_r) - 24'h000001)
    else $error("trace counter did not decrement");
  abortHold_a: assert property (@(posedge clk) disable iff (rst)
    instrExec && instrAbort && st_r != dht_pkg::ST_WR |=> $stable(traceCnt_r))
    else $error("aborted instruction changed trace counter");
  traceEnter_a: assert property (@(posedge clk) disable iff (rst)
    !debugMode_r && instrDone && traceEnable && traceCnt_r == 24'h0
    |=> debugMode_r)
    else $error("trace at zero did not enter debug");
  fetchBp_a: assert property (@(posedge clk) disable iff (rst)
    !debugMode_r && instrDone && bpEnable && bpMatchFetch &&
    bpCnt_r == 24'h0 |=> debugMode_r)
    else $error("fetch breakpoint did not halt");
  dataBpLate_a: assert property (@(posedge clk) disable iff (rst)
    !debugMode_r && !enterNow && instrDone && bpEnable && bpMatchData &&
    bpCnt_r == 24'h0 |=> !debugMode_r && dataBpArm_r)
    else $error("data breakpoint timing wrong");
  dataBpEnter_a: assert property (@(posedge clk) disable iff (rst)
    dataBpArm_r && instrDone |=> debugMode_r)
    else $error("armed data breakpoint did not halt");
  capFrozen_a: assert property (@(posedge clk) disable iff (rst)
    debugMode_r && $past(debugMode_r) |-> $stable(fetchCap_r) &&
    $stable(decodeCap_r) && $stable(execCap_r))
    else $error("capture changed in debug mode");
  entryPtr_a: assert property (@(posedge clk) disable iff (rst)
    enterNow |=> rdPtr_r == $past(wrPtr_r))
    else $error("trace pointer not at oldest");
  ptrWrap_a: assert property (@(posedge clk) disable iff (rst)
    5'(rdPtr_r) < 5'(TRACE_DEPTH) && 5'(wrPtr_r) < 5'(TRACE_DEPTH))
    else $error("trace pointer out of range");
  exchWr_a: assert property (@(posedge clk) disable iff (rst)
    xioWrite && xioAddr == dht_pkg::XIO_EXCH_ADDR |=> exch_r == $past(xioData))
    else $error("exchange latch not written");
  restore_a: assert property (@(posedge clk) disable iff (rst)
    actRestore |=> ilRestore_r && ilRestoreWord_r == $past(dataIn) &&
    !haltAckN_r)
    else $error("restore pulse missing");
  enterCov_c: cover property (@(posedge clk) disable iff (rst) enterNow);
  execCov_c: cover property (@(posedge clk) disable iff (rst)
    st_r == dht_pkg::ST_EXEC ##1 st_r == dht_pkg::ST_CMD);
  traceRdCov_c: cover property (@(posedge clk) disable iff (rst)
    actRead && cmdIn[3:0] == dht_pkg::SEL_TRACE);
  stallCov_c: cover property (@(posedge clk) disable iff (rst)
    bufCnt_r == 2'h2);
endmodule

// >>> test/dht_link_model.sv
module dht_link_model (
  // clock
  input wire logic clk,
  // link pins
  output logic tckPin,
  output logic tdiPin,
  output logic shiftPin,
  output logic updatePin,
  input wire logic tdo_r,
  input wire logic haltAckN_r
);
  timeunit 1ns;
  timeprecision 1ns;
  int ackCount = 0;
  int ackFail = 0;
  logic [24:0] junk;
  initial begin
    tckPin = 1'b0;
    tdiPin = 1'b0;
    shiftPin = 1'b0;
    updatePin = 1'b0;
  end
  // ***************************************************
  // acknowledge pulses seen
  // ***************************************************
  always @(posedge clk) begin
    if (haltAckN_r === 1'b0) begin
      ackCount <= ackCount + 1;
    end
  end
  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask
  // ***************************************************
  // one data scan, then update
  // ***************************************************
  // tck runs only inside a scan, lsb first both ways
  task automatic scan(input int n, input logic [24:0] din,
      output logic [24:0] dout);
    dout = '0;
    ticks(1);
    shiftPin = 1'b1;
    for (int i = 0; i < n; i++) begin
      tdiPin = din[i];
      ticks(4);
      dout[i] = tdo_r;
      tckPin = 1'b1;
      ticks(4);
      tckPin = 1'b0;
    end
    shiftPin = 1'b0;
    // released data line shows the inverse of its last bit
    tdiPin = ~tdiPin;
    updatePin = 1'b1;
    ticks(4);
    updatePin = 1'b0;
    ticks(4);
  endtask
  // next command only after the previous one is acknowledged
  task automatic command(input logic [7:0] cmd, input logic [23:0] data,
      input bit withData, output logic [24:0] dout);
    int b;
    int t;
    b = ackCount;
    dout = '0;
    scan(8, {17'h0, cmd}, junk);
    if (withData) begin
      scan(24, {1'b0, data}, junk);
    end
    if (cmd[7]) begin
      scan(25, 25'h0, dout);
    end
    t = 0;
    while (ackCount == b && t < 2000) begin
      ticks(1);
      t++;
    end
    if (ackCount == b) begin
      ackFail++;
      $display("CHECK FAILED %0t no acknowledge", $time);
    end
  endtask
endmodule

// >>> test/tb_debug_halt_trace_capture.sv
module tb_debug_halt_trace_capture;
  timeunit 1ns;
  timeprecision 1ns;
  // ***************************************************
  // signals
  // ***************************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic tckPin, tdiPin, shiftPin, updatePin, tdo_r, haltAckN_r;
  logic [1:0] coreState_r;
  logic instrExec = 1'b0, instrAbort = 1'b0, execIsHalt = 1'b0;
  logic execIsCondHalt = 1'b0, condTrue = 1'b0, ilLoad = 1'b0;
  logic traceEnable = 1'b0, bpEnable = 1'b0, bpMatchFetch = 1'b0;
  logic bpMatchData = 1'b0, xioWrite = 1'b0, cofValid = 1'b0;
  logic cofCond = 1'b0, cofTaken = 1'b0;
  logic [23:0] progBusVal = '0, instrLatchVal = '0, fetchAddr = '0;
  logic [23:0] decodeAddr = '0, execAddr = '0, xioAddr = '0, xioData = '0;
  logic [23:0] cofAddr = '0, cofTarget = '0;
  logic cofReady_r, debugMode_r, execReq_r, ilRestore_r;
  logic [23:0] execWord_r, ilRestoreWord_r, execSeen, ilSeen;
  logic [24:0] rdVal;
  logic [24:0] expTr[$];
  int n_fail = 0;
  int cmp_count = 0;
  always #25 clk = ~clk;
  dht_debug_halt dht_debug_halt_i (.clk(clk), .rst(rst),
    .tckPin(tckPin), .tdiPin(tdiPin), .shiftPin(shiftPin),
    .updatePin(updatePin), .tdo_r(tdo_r), .haltAckN_r(haltAckN_r),
    .coreState_r(coreState_r), .instrExec(instrExec),
    .instrAbort(instrAbort), .execIsHalt(execIsHalt),
    .execIsCondHalt(execIsCondHalt), .condTrue(condTrue),
    .ilLoad(ilLoad), .traceEnable(traceEnable), .bpEnable(bpEnable),
    .bpMatchFetch(bpMatchFetch), .bpMatchData(bpMatchData),
    .progBusVal(progBusVal), .instrLatchVal(instrLatchVal),
    .fetchAddr(fetchAddr), .decodeAddr(decodeAddr), .execAddr(execAddr),
    .xioWrite(xioWrite), .xioAddr(xioAddr), .xioData(xioData),
    .cofValid(cofValid), .cofCond(cofCond), .cofTaken(cofTaken),
    .cofAddr(cofAddr), .cofTarget(cofTarget), .cofReady_r(cofReady_r),
    .debugMode_r(debugMode_r), .execReq_r(execReq_r),
    .execWord_r(execWord_r), .ilRestore_r(ilRestore_r),
    .ilRestoreWord_r(ilRestoreWord_r));
  dht_link_model dht_link_model_i (.clk(clk), .tckPin(tckPin),
    .tdiPin(tdiPin), .shiftPin(shiftPin), .updatePin(updatePin),
    .tdo_r(tdo_r), .haltAckN_r(haltAckN_r));
  always @(negedge clk) begin
    if (ilRestore_r === 1'b1) begin
      ilSeen = ilRestoreWord_r;
    end
  end
  // ***************************************************
  // helpers
  // ***************************************************
  task automatic check(input logic [24:0] seen, input logic [24:0] exp,
      input string msg);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [23:0] d, input bit w);
    dht_link_model_i.command(c, d, w, rdVal);
  endtask
  task automatic readReg(input logic [3:0] sel, input logic [24:0] exp,
      input string msg);
    dht_link_model_i.command({4'h8, sel}, 24'h0, 1'b0, rdVal);
    check(rdVal, exp, msg);
  endtask
  // f: halt, cond halt, cond, abort, fetch hit, data hit
  task automatic execInstr(input logic [5:0] f);
    @(negedge clk);
    {execIsHalt, execIsCondHalt, condTrue, instrAbort, bpMatchFetch,
      bpMatchData} = f;
    instrExec = 1'b1;
    @(negedge clk);
    {execIsHalt, execIsCondHalt, condTrue, instrAbort, bpMatchFetch,
      bpMatchData} = 6'h0;
    instrExec = 1'b0;
  endtask
  task automatic pulseLoad();
    @(negedge clk);
    ilLoad = 1'b1;
    @(negedge clk);
    ilLoad = 1'b0;
  endtask
  task automatic settle(input logic exp, input string msg);
    ticks(10);
    check({22'h0, coreState_r, debugMode_r}, exp ? 25'h7 : 25'h0, msg);
  endtask
  task automatic leave();
    cmd(8'h60, 24'h0, 1'b0);
    settle(1'b0, "leave");
  endtask
  task automatic coreRespond(input logic [23:0] x);
    int t;
    t = 0;
    while (execReq_r !== 1'b1 && t < 2000) begin
      @(negedge clk);
      t++;
    end
    execSeen = execWord_r;
    ticks(3);
    xioWrite = 1'b1;
    xioAddr = 24'hfffffc;
    xioData = x;
    instrExec = 1'b1;
    @(negedge clk);
    xioWrite = 1'b0;
    instrExec = 1'b0;
  endtask
  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic testFlowHalt();
    logic [23:0] a;
    int b;
    for (int i = 0; i < 7; i++) begin
      a = 24'h000100 + 24'(i * 16);
      @(negedge clk);
      cofValid = 1'b1;
      cofCond = (i % 3 == 2);
      cofTaken = !cofCond;
      cofAddr = a;
      cofTarget = a + 24'h000800;
      b = 0;
      while (cofReady_r !== 1'b1 && b < 50) begin
        @(negedge clk);
        b++;
      end
      @(negedge clk);
      cofValid = 1'b0;
      if (cofCond) begin
        expTr.push_back({a, 1'b1});
      end else begin
        expTr.push_back({a, 1'b0});
        expTr.push_back({a + 24'h000800, 1'b0});
      end
    end
    ticks(20);
    progBusVal = 24'h5a5a01;
    instrLatchVal = 24'h3c3c02;
    fetchAddr = 24'h000210;
    decodeAddr = 24'h00020f;
    execAddr = 24'h00020e;
    execInstr(6'b010000);
    pulseLoad();
    settle(1'b0, "false cond halt");
    execInstr(6'b100000);
    settle(1'b0, "halt before latch load");
    b = dht_link_model_i.ackCount;
    pulseLoad();
    settle(1'b1, "halt entry");
    check(25'(dht_link_model_i.ackCount - b), 25'h1, "entry ack");
    progBusVal = 24'h0;
    instrLatchVal = 24'h0;
    fetchAddr = 24'hffffff;
    decodeAddr = 24'hffffff;
    execAddr = 24'hffffff;
    readReg(dht_pkg::SEL_PBUS, 25'h05a5a01, "saved bus");
    readReg(dht_pkg::SEL_INSTR, 25'h03c3c02, "saved instr");
    readReg(dht_pkg::SEL_FETCH, 25'h0000210, "fetch addr");
    readReg(dht_pkg::SEL_DECODE, 25'h000020f, "decode addr");
    readReg(dht_pkg::SEL_EXEC, 25'h000020e, "exec addr");
    for (int i = 0; i < 24; i++) begin
      readReg(dht_pkg::SEL_TRACE, expTr[i % 12], "trace");
    end
  endtask
  task automatic testExchange();
    @(negedge clk);
    xioWrite = 1'b1;
    xioAddr = 24'hfffffc;
    xioData = 24'h222222;
    @(negedge clk);
    xioAddr = 24'hfffffb;
    xioData = 24'h111111;
    @(negedge clk);
    xioWrite = 1'b0;
    readReg(dht_pkg::SEL_EXCH, 25'h0222222, "exchange");
    fork
      cmd(8'h41, 24'h0a0b0c, 1'b1);
      coreRespond(24'h333333);
    join
    check({1'b0, execSeen}, 25'h00a0b0c, "go word");
    settle(1'b1, "stays in debug");
    readReg(dht_pkg::SEL_EXCH, 25'h0333333, "moved value");
    fork
      cmd(8'h40, 24'h0, 1'b0);
      coreRespond(24'h444444);
    join
    check({1'b0, execSeen}, 25'h00a0b0c, "re-execute");
  endtask
  task automatic testRestore();
    cmd(8'h02, 24'h777777, 1'b1);
    readReg(dht_pkg::SEL_INSTR, 25'h03c3c02, "read only");
    ilSeen = 24'h0;
    cmd(8'h01, 24'h3c3c02, 1'b1);
    check({1'b0, ilSeen}, 25'h03c3c02, "latch restore");
    readReg(dht_pkg::SEL_PBUS, 25'h03c3c02, "bus written");
  endtask
  task automatic testTrace();
    cmd(8'h08, 24'h000002, 1'b1);
    readReg(dht_pkg::SEL_TRACE_CNT, 25'h2, "trace count");
    traceEnable = 1'b1;
    leave();
    execInstr(6'h0);
    execInstr(6'h0);
    execInstr(6'b000100);
    settle(1'b0, "abort at zero");
    execInstr(6'h0);
    settle(1'b1, "trace entry");
    traceEnable = 1'b0;
    readReg(dht_pkg::SEL_TRACE_CNT, 25'h0, "count spent");
  endtask
  task automatic testBreak();
    bpEnable = 1'b1;
    leave();
    execInstr(6'b000010);
    settle(1'b1, "fetch break");
    leave();
    execInstr(6'b000001);
    settle(1'b0, "data break early");
    execInstr(6'h0);
    settle(1'b1, "data break");
    bpEnable = 1'b0;
    leave();
    execInstr(6'b011000);
    pulseLoad();
    settle(1'b1, "cond halt");
  endtask
  // ***************************************************
  // run control
  // ***************************************************
  task automatic end_sim();
    n_fail += dht_link_model_i.ackFail;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    check({18'h0, haltAckN_r, coreState_r, debugMode_r, execReq_r,
      ilRestore_r, cofReady_r}, 25'h40, "reset outputs");
    rst = 1'b0;
    ticks(5);
    testFlowHalt();
    testExchange();
    testRestore();
    testTrace();
    testBreak();
    end_sim();
  end
  initial begin
    #2000000;
    n_fail++;
    $display("CHECK FAILED %0t watchdog", $time);
    end_sim();
  end
endmodule
